// file: design/gpt_pkg.sv
// Contract
// RULE1: Five 16-bit timers in two modules.
// RULE2: Timers run alone or chained within module.
// RULE3: First-module timers select one of four modes.
// RULE4: Timer mode counts prescaled system clock.
// RULE5: Counter mode counts external input pin events.
// RULE6: Gated mode counts only at active gate level.
// RULE7: Finest resolution is four system clocks.
// RULE8: Direction from software or direction pin.
// RULE9: Quadrature phases give count and direction.
// RULE10: Toggle latch flips on core wrap.
// RULE11: Toggle latch optionally drives output pin.
// RULE12: Toggle latch can clock auxiliary timers.
// RULE13: Auxiliary capture or reload mode stops counting.
// RULE14: Capture copies core value on input signal.
// RULE15: Reload core from auxiliary on trigger.
// RULE16: Opposite-edge reloads give continuous PWM.
// RULE17: Some inputs have no pin connection.
// RULE18: Sixteen-bit counters wrap both directions.
// RULE19: External inputs synchronised before use.
package gpt_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] GPT_AUX_A_CTRL = 8'h00;
  localparam logic [7:0] GPT_CORE_CTRL  = 8'h04;
  localparam logic [7:0] GPT_AUX_B_CTRL = 8'h08;
  localparam logic [7:0] GPT_M2_CTRL    = 8'h0c;
  localparam logic [7:0] GPT_M2B_CTRL   = 8'h10;
  localparam logic [7:0] GPT_AUX_A_CNT  = 8'h14;
  localparam logic [7:0] GPT_CORE_CNT   = 8'h18;
  localparam logic [7:0] GPT_AUX_B_CNT  = 8'h1c;
  localparam logic [7:0] GPT_M2_CNT     = 8'h20;
  localparam logic [7:0] GPT_M2B_CNT    = 8'h24;
  localparam logic [7:0] GPT_STATUS     = 8'h28;
  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int GPT_F_PRE  = 0;   // 3 bits, divider 4 << pre
  localparam int GPT_F_MODE = 3;   // 3 bits
  localparam int GPT_F_RUN  = 6;
  localparam int GPT_F_DIR  = 7;   // 1 = down
  localparam int GPT_F_XDIR = 8;   // direction from pin
  localparam int GPT_F_EDGE = 9;   // 2 bits: rise, fall
  localparam int GPT_F_GLVL = 11;  // active gate level
  localparam int GPT_F_OE   = 12;  // toggle latch to pin
  localparam int GPT_F_RTGL = 13;  // 2 bits: reload on latch rise, fall
  localparam int GPT_F_RPIN = 15;  // reload on input pin edge
  localparam logic [15:0] GPT_CTRL_RST = 16'h0000;
  localparam logic [15:0] GPT_CNT_RST  = 16'h0000;
  localparam int GPT_MIN_DIV = 4;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    GPT_M_TIMER   = 3'b000,
    GPT_M_COUNTER = 3'b001,
    GPT_M_GATED   = 3'b010,
    GPT_M_QUAD    = 3'b011,
    GPT_M_RELOAD  = 3'b100,
    GPT_M_CAPTURE = 3'b101,
    GPT_M_CHAIN   = 3'b110
  } gpt_mode_t;
  typedef struct packed {
    logic a_in;
    logic a_dir;
    logic c_in;
    logic c_dir;
    logic b_in;
    logic b_dir;
    logic m2b_in;
  } gpt_pins_t;
endpackage

// file: design/gpt_timer_group.sv
`timescale 1ns/100ps
`default_nettype none
module gpt_timer_group #(
  parameter int W = 16
) (
  // Bus clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // Timer pins
  input  wire gpt_pkg::gpt_pins_t pins,
  output logic              toggle_output_pin
);
  import gpt_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  gpt_pins_t sync1_ff;
  gpt_pins_t sync2_ff;
  gpt_pins_t prev_ff;
  logic [4:0] ext_in;
  logic [4:0] ext_dir;
  logic [4:0] in_rise;
  logic [4:0] in_fall;
  logic [4:0] in_now;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff  <= '0;
    end else begin
      sync1_ff <= pins;       // RULE19
      sync2_ff <= sync1_ff;   // RULE19
      prev_ff  <= sync2_ff;
    end
  end

  // Unbonded inputs are held low.
  assign ext_in  = {sync2_ff.m2b_in, 1'b0, sync2_ff.b_in, sync2_ff.c_in, 1'b0}; // RULE17
  assign ext_dir = {1'b0, 1'b0, 1'b0, sync2_ff.c_dir, 1'b0};                    // RULE17
  assign in_now  = ext_in;
  assign in_rise = ext_in & ~{prev_ff.m2b_in, 1'b0, prev_ff.b_in, prev_ff.c_in, 1'b0};
  assign in_fall = ~ext_in & {prev_ff.m2b_in, 1'b0, prev_ff.b_in, prev_ff.c_in, 1'b0};

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Index 0 aux a, 1 core, 2 aux b, 3 module two core, 4 module two aux.
  logic [15:0]  ctrl_ff [5];
  logic [W-1:0] cnt_ff  [5];
  logic [W-1:0] nxt_cnt [5];
  logic         tgl_ff;
  logic         tgl_rise;
  logic         tgl_fall;
  logic [4:0]   wrap;
  logic [4:0]   tick;
  logic [4:0]   down;

  logic         ap_we_ff;
  logic [7:0]   ap_addr_ff;
  logic         wr_go;
  assign wr_go = ap_we_ff;

  function automatic logic [2:0] mode_of(input logic [15:0] c);
    mode_of = c[GPT_F_MODE +: 3];
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a <= GPT_STATUS) && (a[1:0] == 2'b00);
  endfunction

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  // One free-running counter serves all timers; its low pre+2 bits all set give
  // a tick every 4 << pre clocks, never faster than every four.
  logic [9:0] pre_cnt_ff;
  logic [9:0] pre_nxt;
  assign pre_nxt = pre_cnt_ff + 10'h001;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_ff <= 10'h000;
    end else begin
      pre_cnt_ff <= pre_nxt;
    end
  end

  function automatic logic pre_tick(input logic [2:0] p, input logic [9:0] c);
    logic [9:0] m;
    m = (10'h004 << p) - 10'h001; // RULE7
    pre_tick = ((c & m) == m);
  endfunction

  // ****************************************************************
  // Count sources
  // ****************************************************************
  logic [4:0] q_tick;
  logic       q_dir;
  // Quadrature only on the core timer, where both phases are bonded.
  assign q_tick = {4'h0, 1'b0} | {3'h0, (sync2_ff.c_in ^ prev_ff.c_in)
                  | (sync2_ff.c_dir ^ prev_ff.c_dir), 1'b0};                    // RULE9
  assign q_dir  = sync2_ff.c_dir ^ prev_ff.c_in;                                // RULE9

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      logic [15:0] c;
      c = ctrl_ff[i];
      tick[i] = 1'b0;
      down[i] = c[GPT_F_XDIR] ? (c[GPT_F_DIR] ^ ext_dir[i]) : c[GPT_F_DIR];   // RULE8
      if (c[GPT_F_RUN]) begin
        unique case (gpt_mode_t'(mode_of(c)))
          GPT_M_TIMER:   tick[i] = pre_tick(c[GPT_F_PRE +: 3], pre_cnt_ff);   // RULE4
          GPT_M_GATED:   tick[i] = pre_tick(c[GPT_F_PRE +: 3], pre_cnt_ff)
                                   && (in_now[i] == c[GPT_F_GLVL]);           // RULE6
          GPT_M_COUNTER: tick[i] = (c[GPT_F_EDGE] & in_rise[i])
                                   | (c[GPT_F_EDGE + 1] & in_fall[i]);        // RULE5
          GPT_M_QUAD: begin
            tick[i] = q_tick[i];                                              // RULE9
            down[i] = (i == 1) ? q_dir : down[i];
          end
          GPT_M_CHAIN: begin
            // Auxiliaries take the core toggle latch; module two aux takes its core wrap.
            if (i == 0 || i == 2) begin
              tick[i] = (c[GPT_F_EDGE] & tgl_rise) | (c[GPT_F_EDGE + 1] & tgl_fall); // RULE12
            end else if (i == 4) begin
              tick[i] = wrap[3];                                              // RULE2
            end
          end
          default: tick[i] = 1'b0;  // RULE13
        endcase
      end
    end
  end

  // ****************************************************************
  // Counters
  // ****************************************************************
  logic cap_a;
  logic cap_b;
  logic rel_a;
  logic rel_b;

  function automatic logic rel_trig(input logic [15:0] c, input logic r, input logic f,
                                    input logic pin_edge);
    rel_trig = (mode_of(c) == GPT_M_RELOAD) &&
               ((c[GPT_F_RTGL] & r) | (c[GPT_F_RTGL + 1] & f) | (c[GPT_F_RPIN] & pin_edge));
  endfunction

  assign cap_a = (mode_of(ctrl_ff[0]) == GPT_M_CAPTURE) &&
                 ((ctrl_ff[0][GPT_F_EDGE] & in_rise[0]) | (ctrl_ff[0][GPT_F_EDGE+1] & in_fall[0]));
  assign cap_b = (mode_of(ctrl_ff[2]) == GPT_M_CAPTURE) &&
                 ((ctrl_ff[2][GPT_F_EDGE] & in_rise[2]) | (ctrl_ff[2][GPT_F_EDGE+1] & in_fall[2]));
  assign rel_a = rel_trig(ctrl_ff[0], tgl_rise, tgl_fall, in_rise[0] | in_fall[0]);  // RULE15
  assign rel_b = rel_trig(ctrl_ff[2], tgl_rise, tgl_fall, in_rise[2] | in_fall[2]);  // RULE15

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      nxt_cnt[i] = tick[i] ? (down[i] ? cnt_ff[i] - 1'b1 : cnt_ff[i] + 1'b1) : cnt_ff[i]; // RULE18
      wrap[i] = tick[i] && (down[i] ? (cnt_ff[i] == '0) : (cnt_ff[i] == '1));             // RULE18
    end
  end

  // Latch transitions are taken from the stored latch, so a reload
  // lands one clock after the wrap that flipped it.
  logic tgl_prev_ff;
  assign tgl_rise = tgl_ff & ~tgl_prev_ff;
  assign tgl_fall = ~tgl_ff & tgl_prev_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgl_ff      <= 1'b0;
      tgl_prev_ff <= 1'b0;
    end else begin
      tgl_prev_ff <= tgl_ff;
      if (wrap[1]) begin
        tgl_ff <= ~tgl_ff;  // RULE10
      end
    end
  end

  assign toggle_output_pin = tgl_ff & ctrl_ff[1][GPT_F_OE];  // RULE11

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 5; i++) begin
        cnt_ff[i] <= GPT_CNT_RST;  // RULE1
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (wr_go && ap_addr_ff == GPT_AUX_A_CNT + 8'(4 * i)) begin
          cnt_ff[i] <= hwdata[W-1:0];
        end else if (i == 1 && rel_a) begin
          cnt_ff[i] <= cnt_ff[0];  // RULE16
        end else if (i == 1 && rel_b) begin
          cnt_ff[i] <= cnt_ff[2];  // RULE16
        end else if (i == 0 && cap_a) begin
          cnt_ff[i] <= cnt_ff[1];  // RULE14
        end else if (i == 2 && cap_b) begin
          cnt_ff[i] <= cnt_ff[1];  // RULE14
        end else begin
          cnt_ff[i] <= nxt_cnt[i];
        end
      end
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Zero wait states; software writes win over hardware updates.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_we_ff   <= 1'b0;
      ap_addr_ff <= 8'h00;
    end else if (hready) begin
      ap_we_ff   <= hsel && htrans[1] && hwrite && reg_hit(haddr[7:0]) && (haddr[31:8] == '0);
      ap_addr_ff <= haddr[7:0];
    end else begin
      ap_we_ff   <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 5; i++) begin
        ctrl_ff[i] <= GPT_CTRL_RST;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (wr_go && ap_addr_ff == GPT_AUX_A_CTRL + 8'(4 * i)) begin
          ctrl_ff[i] <= hwdata[15:0];  // RULE3
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= 32'h0000_0000;
      if (hready && hsel && htrans[1] && !hwrite && haddr[31:8] == '0) begin
        for (int i = 0; i < 5; i++) begin
          if (haddr[7:0] == GPT_AUX_A_CTRL + 8'(4 * i)) begin
            hrdata <= {16'h0000, ctrl_ff[i]};
          end
          if (haddr[7:0] == GPT_AUX_A_CNT + 8'(4 * i)) begin
            hrdata <= {16'h0000, cnt_ff[i]};
          end
        end
        if (haddr[7:0] == GPT_STATUS) begin
          hrdata <= {31'h0, tgl_ff};
        end
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule
`default_nettype wire

// file: verification/gpt_props.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checker
// ****
module gpt_props (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Timer output
  input wire logic        toggle_output_pin
);
  import gpt_pkg::*;
  logic        rd_ff;
  logic        wr_ff;
  logic        oe_ff;
  logic [31:0] adr_ff;
  wire         take = hsel && htrans[1] && hready;
  // The pin is gated by the enable, so the enable is mirrored from bus writes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      oe_ff <= 1'b0;
      adr_ff <= 32'h0;
    end else begin
      rd_ff <= take && !hwrite;
      wr_ff <= take && hwrite;
      adr_ff <= haddr;
      if (wr_ff && adr_ff == {24'h0, GPT_CORE_CTRL}) begin
        oe_ff <= hwdata[GPT_F_OE];
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout) else $error("ready low");
  a_resp_okay: assert property (!hresp) else $error("response not okay");
  a_unmapped_zero:
    assert property (take && !hwrite && haddr > 32'h28 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (rd_ff |-> hrdata[31:16] == 16'h0)
    else $error("upper half set");
  a_status_bits:
    assert property (rd_ff && adr_ff == {24'h0, GPT_STATUS} |-> hrdata[31:1] == 31'h0)
    else $error("status spare bits set");
  a_pin_enabled: assert property (toggle_output_pin |-> oe_ff || $past(oe_ff))
    else $error("pin driven while disabled");
  a_toggle_gap:
    assert property (oe_ff && $past(oe_ff, 4) && $changed(toggle_output_pin)
      |=> $stable(toggle_output_pin)[*3])
    else $error("latch flips too fast");
  a_reset_quiet:
    assert property (disable iff (1'b0) !hresetn |-> !toggle_output_pin && hrdata == 32'h0)
    else $error("outputs active in reset");
  c_toggle: cover property ($rose(toggle_output_pin));
  c_unmapped: cover property (take && haddr > 32'h28);
  c_status: cover property (rd_ff && adr_ff == {24'h0, GPT_STATUS});
endmodule
bind gpt_timer_group gpt_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .toggle_output_pin);
`default_nettype wire

// file: verification/gpt_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Sensor and pin model
// ****
module gpt_pins_model (
  // Clock
  input wire logic           hclk,
  // Controls
  input wire logic           gate,
  input wire logic           quad_run,
  input wire logic           quad_down,
  input wire logic           cap,
  // Pins
  output var gpt_pkg::gpt_pins_t pins
);
  import gpt_pkg::*;
  logic [2:0] div_ff = 3'h0;
  logic [1:0] pos_ff = 2'h0;
  logic       junk_ff = 1'b0;
  // One phase step per eight clocks, so every edge outlasts the synchroniser.
  always_ff @(posedge hclk) begin
    div_ff <= div_ff + 3'h1;
    junk_ff <= ~junk_ff;
    if (quad_run && div_ff == 3'h7) begin
      pos_ff <= quad_down ? pos_ff - 2'h1 : pos_ff + 2'h1;
    end
  end
  // Unwired inputs chatter every cycle; the timers must ignore them.
  always_comb begin
    pins.a_in = junk_ff;
    pins.a_dir = ~junk_ff;
    pins.c_in = quad_run ? pos_ff[1] : gate;
    pins.c_dir = pos_ff[1] ^ pos_ff[0];
    pins.b_in = cap;
    pins.b_dir = junk_ff;
    pins.m2b_in = 1'b0;
  end
endmodule
`default_nettype wire

// file: verification/gpt_timer_group_tb.sv
`timescale 1ns/100ps
`default_nettype none
module gpt_timer_group_tb;
  import gpt_pkg::*;
  localparam logic [15:0] RUN = 16'(1 << GPT_F_RUN);
  localparam logic [15:0] OE = 16'(1 << GPT_F_OE);
  logic hclk = 1'b0, hresetn = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic gate = 1'b0, qrun = 1'b0, qdown = 1'b0, cap = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
  logic [15:0] w, d, e;
  logic hreadyout, hresp, tog;
  gpt_pins_t pins;
  int fails = 0, samples_checked = 0, hi_n, lo_n;
  always #2 hclk = ~hclk;
  gpt_timer_group dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pins, .toggle_output_pin(tog));
  gpt_pins_model u_pins (.hclk, .gate, .quad_run(qrun), .quad_down(qdown), .cap, .pins);
  task automatic summarize;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic hwait;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      summarize();
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] dat);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, dat};
    hwait();
    v = hrdata;
  endtask
  // Two reads exactly n cycles apart; d is the change between them.
  task automatic meas(input logic [7:0] a, input int n);
    xfer(1'b0, a, 16'h0);
    w = v[15:0];
    repeat (n - 3) @(posedge hclk);
    xfer(1'b0, a, 16'h0);
    d = v[15:0] - w;
  endtask
  task automatic hold(input logic lvl, output int n);
    n = 0;
    while (tog === lvl && n < 500) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 500) begin
      fails++;
      summarize();
    end
  endtask
  function automatic logic [15:0] cfg(input logic [2:0] p, input gpt_mode_t m,
                                      input logic [15:0] f);
    return {10'h0, m, p} | f;
  endfunction
  initial begin
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      xfer(1'b0, 8'(i * 4), 16'h0);
      chk(v === 32'h0, "reset value");
    end
    xfer(1'b1, 8'h2c, 16'h1234);
    xfer(1'b0, 8'h2c, 16'h0);
    chk(v === 32'h0, "unmapped read");
    for (int p = 0; p < 3; p++) begin
      xfer(1'b1, GPT_CORE_CTRL, cfg(3'(p), GPT_M_TIMER, RUN));
      meas(GPT_CORE_CNT, 40 << p);
      chk(d === 16'd10, "prescaled rate");
    end
    for (int g = 0; g < 2; g++) begin
      gate <= g[0];
      xfer(1'b1, GPT_CORE_CTRL, cfg(3'h0, GPT_M_GATED, RUN | 16'(1 << GPT_F_GLVL)));
      meas(GPT_CORE_CNT, 40);
      chk(d === 16'(g * 10), "gated rate");
    end
    xfer(1'b1, GPT_CORE_CNT, 16'h0004);
    xfer(1'b1, GPT_CORE_CTRL, cfg(3'h0, GPT_M_TIMER, RUN | OE | 16'(1 << GPT_F_DIR)));
    meas(GPT_CORE_CNT, 40);
    chk(d === 16'hfff6 && tog === 1'b1, "down wrap");
    xfer(1'b0, GPT_STATUS, 16'h0);
    chk(v === 32'h1, "latch status");
    xfer(1'b1, GPT_CORE_CNT, 16'hfff8);
    xfer(1'b1, GPT_CORE_CTRL, cfg(3'h0, GPT_M_TIMER, RUN | OE));
    meas(GPT_CORE_CNT, 80);
    chk(d === 16'd20 && tog === 1'b0, "up wrap");
    xfer(1'b1, GPT_CORE_CTRL, cfg(3'h0, GPT_M_QUAD, RUN));
    qrun <= 1'b1;
    meas(GPT_CORE_CNT, 160);
    e = d;
    qdown <= 1'b1;
    meas(GPT_CORE_CNT, 160);
    chk(e !== 16'h0 && 16'(e + d + 16'd2) <= 16'd4, "quad tracking");
    qrun <= 1'b0;
    xfer(1'b1, GPT_CORE_CTRL, cfg(3'h0, GPT_M_TIMER, RUN));
    xfer(1'b1, GPT_AUX_B_CTRL, cfg(3'h0, GPT_M_CAPTURE, 16'(1 << GPT_F_EDGE)));
    cap <= 1'b1;
    repeat (8) @(posedge hclk);
    xfer(1'b0, GPT_AUX_B_CNT, 16'h0);
    w = v[15:0];
    xfer(1'b0, GPT_CORE_CNT, 16'h0);
    chk(16'(v[15:0] - w - 16'd1) <= 16'd4, "capture value");
    cap <= 1'b0;
    meas(GPT_AUX_B_CNT, 40);
    chk(d === 16'h0, "capture holds");
    xfer(1'b1, GPT_AUX_A_CNT, 16'hfff0);
    xfer(1'b1, GPT_AUX_B_CNT, 16'hffe0);
    xfer(1'b1, GPT_AUX_A_CTRL, cfg(3'h0, GPT_M_RELOAD, 16'(1 << GPT_F_RTGL)));
    xfer(1'b1, GPT_AUX_B_CTRL, cfg(3'h0, GPT_M_RELOAD, 16'(2 << GPT_F_RTGL)));
    xfer(1'b1, GPT_CORE_CNT, 16'hfff0);
    xfer(1'b1, GPT_CORE_CTRL, cfg(3'h0, GPT_M_TIMER, RUN | OE));
    hold(1'b1, hi_n);
    hold(1'b0, lo_n);
    hold(1'b1, hi_n);
    hold(1'b0, lo_n);
    chk(hi_n inside {[60:68]} && lo_n inside {[124:132]}, "pwm phases");
    xfer(1'b0, GPT_AUX_A_CNT, 16'h0);
    chk(v === 32'hfff0, "reload source kept");
    xfer(1'b1, GPT_AUX_A_CTRL, 16'h0);
    xfer(1'b1, GPT_AUX_B_CTRL, cfg(3'h0, GPT_M_CHAIN, RUN | 16'(3 << GPT_F_EDGE)));
    xfer(1'b1, GPT_CORE_CNT, 16'hfffa);
    meas(GPT_AUX_B_CNT, 100);
    chk(d === 16'h1, "chained latch count");
    gate <= 1'b0;
    xfer(1'b1, GPT_CORE_CTRL, cfg(3'h0, GPT_M_COUNTER, RUN | 16'(1 << GPT_F_EDGE)));
    xfer(1'b1, GPT_CORE_CNT, 16'h0);
    repeat (5) begin
      gate <= 1'b1;
      repeat (4) @(posedge hclk);
      gate <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    repeat (4) @(posedge hclk);
    xfer(1'b0, GPT_CORE_CNT, 16'h0);
    chk(v === 32'h5, "event count");
    summarize();
  end
endmodule
`default_nettype wire
